// ### verilog/bsc_tap.sv
// test access port top: controller, instruction and data registers
// assumes tck, tms, tdi and pins are asynchronous; cfg_busy and user_sig are on mclk
`timescale 1ns/100ps
module bsc_tap
  import bsc_pkg::*;
#(
  parameter int BSR_LEN = BSR_LEN_DEF,
  parameter logic [VER_W-1:0] ID_VER = ID_VER_DEF,
  parameter logic [PART_W-1:0] ID_PART = ID_PART_DEF,
  parameter logic [MFR_W-1:0] ID_MFR = ID_MFR_DEF,
  parameter logic [UCODE_FIX_W-1:0] UCODE_FIX = UCODE_FIX_DEF
) (
  input wire logic mclk,                  // system clock, 125 MHz
  input wire logic rstn,                  // async reset, active low
  input wire logic tck,                   // test clock pin
  input wire logic tms,                   // mode select pin
  input wire logic tdi,                   // serial data in pin
  output logic tdo,                       // serial data out
  output logic tdo_oe_n,                  // data out enable, low drives
  input wire logic [BSR_LEN-1:0] pin_in,  // pin levels
  input wire logic [BSR_LEN-1:0] core_out, // core values for pins
  output logic [BSR_LEN-1:0] pin_out,     // pin drive
  input wire logic cfg_busy,              // configuration in progress
  input wire logic [UCODE_USER_W-1:0] user_sig, // configured signature bits
  output logic cfg_bit,                   // configuration data bit
  output logic cfg_bit_vld,               // pulse, cfg_bit valid
  output logic cfg_start                  // pulse, start configuration
);
  // msb first, constant one at bit zero
  localparam logic [D32_W-1:0] ID_WORD = {ID_VER, ID_PART, ID_MFR, ID_LSB};

  logic tck_s, tms_s, tdi_s;
  logic [BSR_LEN-1:0] pin_s;
  logic tck_d_r, tck_d_nxt;
  bsc_state_t st_r, st_nxt;
  logic [IR_W-1:0] ir_sh_r, ir_sh_nxt;
  logic [IR_W-1:0] ir_r, ir_nxt;
  logic byp_r, byp_nxt;
  logic [D32_W-1:0] d32_r, d32_nxt;
  logic tdo_r, tdo_nxt;
  logic tdo_oe_n_r, tdo_oe_n_nxt;
  logic cfg_bit_r, cfg_bit_nxt;
  logic cfg_vld_r, cfg_vld_nxt;
  logic cfg_start_r, cfg_start_nxt;
  logic rise, fall;
  logic bsr_cap, bsr_shift, bsr_upd, extest_act, bsr_so, dr_so;
  bsc_drsel_t drsel;

  // controller transition on one sampled mode-select bit
  function automatic bsc_state_t tap_next(bsc_state_t s, logic m);
    unique case (s)
      ST_TLR: tap_next = m ? ST_TLR : ST_RTI;
      ST_RTI: tap_next = m ? ST_SELDR : ST_RTI;
      ST_SELDR: tap_next = m ? ST_SELIR : ST_CAPDR;
      ST_CAPDR: tap_next = m ? ST_EX1DR : ST_SHDR;
      ST_SHDR: tap_next = m ? ST_EX1DR : ST_SHDR;
      ST_EX1DR: tap_next = m ? ST_UPDR : ST_PAUSEDR;
      ST_PAUSEDR: tap_next = m ? ST_EX2DR : ST_PAUSEDR;
      ST_EX2DR: tap_next = m ? ST_UPDR : ST_SHDR;
      ST_UPDR: tap_next = m ? ST_SELDR : ST_RTI;
      ST_SELIR: tap_next = m ? ST_TLR : ST_CAPIR;
      ST_CAPIR: tap_next = m ? ST_EX1IR : ST_SHIR;
      ST_SHIR: tap_next = m ? ST_EX1IR : ST_SHIR;
      ST_EX1IR: tap_next = m ? ST_UPIR : ST_PAUSEIR;
      ST_PAUSEIR: tap_next = m ? ST_EX2IR : ST_PAUSEIR;
      ST_EX2IR: tap_next = m ? ST_UPIR : ST_SHIR;
      ST_UPIR: tap_next = m ? ST_SELDR : ST_RTI;
    endcase
  endfunction

  // unknown opcodes fall back to the one-stage path
  function automatic bsc_drsel_t dr_decode(logic [IR_W-1:0] op);
    if (op == OP_EXTEST || op == OP_SAMPLE) begin
      dr_decode = DRS_BSR;
    end else if (op == OP_IDCODE || op == OP_USERCODE) begin
      dr_decode = DRS_D32;
    end else if (op == OP_CFG_LOAD) begin
      dr_decode = DRS_CFG;
    end else begin
      dr_decode = DRS_BYP;
    end
  endfunction

  // pins and test clock cross into mclk here
  bsc_sync #(.W(3)) u_sync_tap (
    .mclk(mclk),
    .rstn(rstn),
    .d({tck, tms, tdi}),
    .q({tck_s, tms_s, tdi_s})
  );
  bsc_sync #(.W(BSR_LEN)) u_sync_pins (
    .mclk(mclk),
    .rstn(rstn),
    .d(pin_in),
    .q(pin_s)
  );

  // edge detect on the synchronised test clock; all three pins share latency
  assign rise = tck_s & ~tck_d_r;
  assign fall = ~tck_s & tck_d_r;
  assign drsel = dr_decode(ir_r);

  assign extest_act = (ir_r == OP_EXTEST) && !cfg_busy;
  assign bsr_cap = rise && st_r == ST_CAPDR && drsel == DRS_BSR && !cfg_busy;
  assign bsr_shift = rise && st_r == ST_SHDR && drsel == DRS_BSR;
  assign bsr_upd = rise && st_r == ST_UPDR && drsel == DRS_BSR && !cfg_busy;

  bsc_chain #(.LEN(BSR_LEN)) u_chain (
    .mclk(mclk),
    .rstn(rstn),
    .cap_en(bsr_cap),
    .shift_en(bsr_shift),
    .upd_en(bsr_upd),
    .extest(extest_act),
    .tdi(tdi_s),
    .pin_in(pin_s),
    .core_out(core_out),
    .so(bsr_so),
    .pin_out(pin_out)
  );

  // serial out of the selected data path
  always_comb begin
    unique case (drsel)
      DRS_BSR: dr_so = bsr_so;
      DRS_D32: dr_so = d32_r[0];
      DRS_CFG: dr_so = tdi_s;
      DRS_BYP: dr_so = byp_r;
    endcase
  end

  // next values for controller, registers and outputs
  always_comb begin
    tck_d_nxt = tck_s;
    st_nxt = st_r;
    ir_sh_nxt = ir_sh_r;
    ir_nxt = ir_r;
    byp_nxt = byp_r;
    d32_nxt = d32_r;
    tdo_nxt = tdo_r;
    tdo_oe_n_nxt = tdo_oe_n_r;
    cfg_bit_nxt = cfg_bit_r;
    cfg_vld_nxt = 1'b0;
    cfg_start_nxt = 1'b0;
    if (rise) begin
      st_nxt = tap_next(st_r, tms_s);
      unique case (st_r)
        ST_TLR: begin
          ir_nxt = OP_IDCODE;
        end
        ST_CAPIR: begin
          ir_sh_nxt = {{(IR_W-2){1'b0}}, IR_CAP_PAT};
        end
        ST_SHIR: begin
          ir_sh_nxt = {tdi_s, ir_sh_r[IR_W-1:1]};
        end
        ST_UPIR: begin
          ir_nxt = ir_sh_r;
        end
        ST_CAPDR: begin
          byp_nxt = 1'b0;
          if (ir_r == OP_IDCODE) begin
            d32_nxt = ID_WORD;
          end else if (ir_r == OP_USERCODE) begin
            d32_nxt = {UCODE_FIX, user_sig};
          end
        end
        ST_SHDR: begin
          byp_nxt = tdi_s;
          if (drsel == DRS_D32) begin
            d32_nxt = {tdi_s, d32_r[D32_W-1:1]};
          end
          if (drsel == DRS_CFG) begin
            cfg_bit_nxt = tdi_s;
            cfg_vld_nxt = 1'b1;
          end
        end
        ST_UPDR: begin
          cfg_start_nxt = (ir_r == OP_CFG_START);
        end
        default: begin
        end
      endcase
    end
    if (fall) begin
      // data out changes on falling edge
      tdo_oe_n_nxt = !(st_r == ST_SHDR || st_r == ST_SHIR);
      if (st_r == ST_SHIR) begin
        tdo_nxt = ir_sh_r[0];
      end else if (st_r == ST_SHDR) begin
        tdo_nxt = dr_so;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tck_d_r <= 1'b0;
      st_r <= ST_TLR;
      ir_sh_r <= '0;
      ir_r <= OP_IDCODE;
      byp_r <= 1'b0;
      d32_r <= '0;
      tdo_r <= 1'b0;
      tdo_oe_n_r <= 1'b1;
      cfg_bit_r <= 1'b0;
      cfg_vld_r <= 1'b0;
      cfg_start_r <= 1'b0;
    end else begin
      tck_d_r <= tck_d_nxt;
      st_r <= st_nxt;
      ir_sh_r <= ir_sh_nxt;
      ir_r <= ir_nxt;
      byp_r <= byp_nxt;
      d32_r <= d32_nxt;
      tdo_r <= tdo_nxt;
      tdo_oe_n_r <= tdo_oe_n_nxt;
      cfg_bit_r <= cfg_bit_nxt;
      cfg_vld_r <= cfg_vld_nxt;
      cfg_start_r <= cfg_start_nxt;
    end
  end

  assign tdo = tdo_r;
  assign tdo_oe_n = tdo_oe_n_r;
  assign cfg_bit = cfg_bit_r;
  assign cfg_bit_vld = cfg_vld_r;
  assign cfg_start = cfg_start_r;

  // checks
  // busy blocks boundary
  AST_CFG_BLOCKS_SCAN: assert property (@(posedge mclk) disable iff (!rstn)
    cfg_busy |-> !bsr_cap && !bsr_upd && !extest_act)
    else $error("boundary activity during configuration");
  AST_CFG_PINS_CORE: assert property (@(posedge mclk) disable iff (!rstn)
    cfg_busy |=> pin_out == $past(core_out))
    else $error("pins left core values during configuration");
  AST_IR_CAPTURE: assert property (@(posedge mclk) disable iff (!rstn)
    rise && st_r == ST_CAPIR |=> ir_sh_r == {{(IR_W-2){1'b0}}, IR_CAP_PAT})
    else $error("instruction capture pattern wrong");
  AST_IR_UPDATE: assert property (@(posedge mclk) disable iff (!rstn)
    rise && st_r == ST_UPIR |=> ir_r == $past(ir_sh_r))
    else $error("instruction not loaded at update");
  AST_RESET_IDCODE: assert property (@(posedge mclk) disable iff (!rstn)
    rise && st_r == ST_TLR |=> ir_r == OP_IDCODE)
    else $error("reset state did not select identity");
  AST_ID_WORD: assert property (@(posedge mclk) disable iff (!rstn)
    rise && st_r == ST_CAPDR && ir_r == OP_IDCODE |=> d32_r[0] && d32_r == ID_WORD)
    else $error("identity word not captured");
  AST_USERCODE: assert property (@(posedge mclk) disable iff (!rstn)
    rise && st_r == ST_CAPDR && ir_r == OP_USERCODE
      |=> d32_r == {UCODE_FIX, $past(user_sig)})
    else $error("user signature not captured");
  AST_BYPASS_ZERO: assert property (@(posedge mclk) disable iff (!rstn)
    rise && st_r == ST_CAPDR |=> !byp_r)
    else $error("bypass stage not cleared at capture");
  AST_BYPASS_SHIFT: assert property (@(posedge mclk) disable iff (!rstn)
    rise && st_r == ST_SHDR |=> byp_r == $past(tdi_s))
    else $error("bypass stage did not take serial in");
  AST_TDO_SHIFT_DATA: assert property (@(posedge mclk) disable iff (!rstn)
    fall && st_r == ST_SHDR && drsel == DRS_D32 |=> tdo == $past(d32_r[0]))
    else $error("data out does not show the word lsb");
  AST_TDO_ENABLE: assert property (@(posedge mclk) disable iff (!rstn)
    fall && (st_r == ST_SHDR || st_r == ST_SHIR) |=> !tdo_oe_n ##1 !tdo_oe_n)
    else $error("data out not enabled in shift");
  AST_TDO_RELEASE: assert property (@(posedge mclk) disable iff (!rstn)
    fall && st_r != ST_SHDR && st_r != ST_SHIR |=> tdo_oe_n)
    else $error("data out driven outside shift");
  AST_CFG_STREAM: assert property (@(posedge mclk) disable iff (!rstn)
    cfg_bit_vld |-> $past(ir_r) == OP_CFG_LOAD && cfg_bit == $past(tdi_s))
    else $error("configuration bit outside load instruction");
  AST_CFG_START_PULSE: assert property (@(posedge mclk) disable iff (!rstn)
    cfg_start |-> $past(rise) && $past(st_r) == ST_UPDR && $past(ir_r) == OP_CFG_START)
    else $error("configuration start outside its update");
  AST_TDO_FALL_ONLY: assert property (@(posedge mclk) disable iff (!rstn)
    !$past(fall) |-> $stable(tdo))
    else $error("data out changed off a falling edge");
  // main scenarios
  COV_ID_SHIFT: cover property (@(posedge mclk) disable iff (!rstn)
    rise && st_r == ST_SHDR && ir_r == OP_IDCODE);
  COV_EXTEST_UPD: cover property (@(posedge mclk) disable iff (!rstn)
    bsr_upd && extest_act);
  COV_CFG_BIT: cover property (@(posedge mclk) disable iff (!rstn) cfg_bit_vld);
  COV_BYP_SHIFT: cover property (@(posedge mclk) disable iff (!rstn)
    rise && st_r == ST_SHDR && drsel == DRS_BYP);
  COV_CFG_START: cover property (@(posedge mclk) disable iff (!rstn) cfg_start);
endmodule // bsc_tap

// ### verilog/bsc_pkg.sv
// constants, opcodes and state codes for the pin scan test port
// assumes one system clock samples the slow serial test pins
//
// How it works
// - boundary capture, update and pin drive are held off while configuration is busy.
// - sample/preload captures pin states without touching the pins and keeps a shifted pattern.
// - extest drives the updated boundary pattern onto the pins and captures the input levels.
// - bypass puts one stage, loaded with zero at capture, between serial in and serial out.
// - user-code puts the 32-bit user signature between serial in and serial out.
// - identification puts the 32-bit identity word between serial in and serial out.
// - the instruction register is ten bits and captures the fixed pattern 01 in its low bits.
// - the user signature is seven configured bits under twenty-five fixed bits.
// - the boundary chain length is a parameter, 690 by default, with 798, 1050, 1308 or 1446.
// - the identity word is version, part number, maker field and a constant one.
// - the configuration load instruction streams shifted bits to the configuration loader; configuration start only pulses cfg_start at update.
// - the identity word shifts out least significant bit first, so its constant one shifts out first.
package bsc_pkg;
  localparam int IR_W = 10;
  localparam int D32_W = 32;
  localparam int UCODE_USER_W = 7;
  localparam int UCODE_FIX_W = 25;
  localparam int VER_W = 4;
  localparam int PART_W = 16;
  localparam int MFR_W = 11;
  localparam int BSR_LEN_DEF = 690;

  localparam logic [IR_W-1:0] OP_EXTEST = 10'h000;
  localparam logic [IR_W-1:0] OP_SAMPLE = 10'h005;
  localparam logic [IR_W-1:0] OP_IDCODE = 10'h006;
  localparam logic [IR_W-1:0] OP_USERCODE = 10'h007;
  localparam logic [IR_W-1:0] OP_CFG_LOAD = 10'h002;
  localparam logic [IR_W-1:0] OP_CFG_START = 10'h003;
  localparam logic [IR_W-1:0] OP_BYPASS = 10'h3ff;
  localparam logic [1:0] IR_CAP_PAT = 2'h1;

  // identity fields: values arbitrary, not any real part
  localparam logic [VER_W-1:0] ID_VER_DEF = 4'h3;
  localparam logic [PART_W-1:0] ID_PART_DEF = 16'h5a5a;
  localparam logic [MFR_W-1:0] ID_MFR_DEF = 11'h2a5;
  localparam logic ID_LSB = 1'h1;
  // fixed user-code bits: value arbitrary
  localparam logic [UCODE_FIX_W-1:0] UCODE_FIX_DEF = 25'h0abcdef;

  // one bit changes per step along the reset, data and instruction walks
  typedef enum logic [3:0] {
    ST_TLR = 4'h0, ST_RTI = 4'h1, ST_SELDR = 4'h3, ST_CAPDR = 4'h2,
    ST_SHDR = 4'h6, ST_EX1DR = 4'h7, ST_PAUSEDR = 4'h4, ST_EX2DR = 4'hc,
    ST_UPDR = 4'h5, ST_SELIR = 4'hb, ST_CAPIR = 4'ha, ST_SHIR = 4'he,
    ST_EX1IR = 4'hf, ST_PAUSEIR = 4'h9, ST_EX2IR = 4'h8, ST_UPIR = 4'hd
  } bsc_state_t;

  typedef enum logic [1:0] {
    DRS_BSR = 2'h0, DRS_BYP = 2'h1, DRS_D32 = 2'h3, DRS_CFG = 2'h2
  } bsc_drsel_t;
endpackage

// ### verilog/bsc_sync.sv
// two-flop synchroniser for pins from outside the mclk domain
// assumes inputs change slowly against mclk
`timescale 1ns/100ps
module bsc_sync #(
  parameter int W = 1
) (
  input wire logic mclk,          // system clock
  input wire logic rstn,          // async reset, active low
  input wire logic [W-1:0] d,     // asynchronous input
  output logic [W-1:0] q          // synchronised level
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // first stage feeds only the second
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;
endmodule // bsc_sync

// ### verilog/bsc_chain.sv
// boundary chain: capture, shift and update cells plus registered pin drive
// assumes strobes are one-cycle pulses from the tap controller
`timescale 1ns/100ps
module bsc_chain
  import bsc_pkg::*;
#(
  parameter int LEN = BSR_LEN_DEF
) (
  input wire logic mclk,              // system clock
  input wire logic rstn,              // async reset, active low
  input wire logic cap_en,            // capture pulse
  input wire logic shift_en,          // shift pulse
  input wire logic upd_en,            // update pulse
  input wire logic extest,            // pins follow update cells
  input wire logic tdi,               // serial in
  input wire logic [LEN-1:0] pin_in,  // synchronised pin levels
  input wire logic [LEN-1:0] core_out, // core values for the pins
  output logic so,                    // serial out, lsb of chain
  output logic [LEN-1:0] pin_out      // registered pin drive
);
  logic [LEN-1:0] sh_r, sh_nxt;
  logic [LEN-1:0] upd_r, upd_nxt;
  logic [LEN-1:0] pout_r, pout_nxt;

  // next values of capture/shift and update stages
  always_comb begin
    sh_nxt = sh_r;
    upd_nxt = upd_r;
    if (cap_en) begin
      sh_nxt = pin_in;
    end else if (shift_en) begin
      sh_nxt = {tdi, sh_r[LEN-1:1]};
    end
    if (upd_en) begin
      upd_nxt = sh_r;
    end
    pout_nxt = extest ? upd_r : core_out;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sh_r <= '0;
      upd_r <= '0;
      pout_r <= '0;
    end else begin
      sh_r <= sh_nxt;
      upd_r <= upd_nxt;
      pout_r <= pout_nxt;
    end
  end

  assign so = sh_r[0];
  assign pin_out = pout_r;

  AST_EXTEST_DRIVE: assert property (@(posedge mclk) disable iff (!rstn)
    extest |=> pin_out == $past(upd_r))
    else $error("pins do not follow update cells under extest");
  AST_NORMAL_PASS: assert property (@(posedge mclk) disable iff (!rstn)
    !extest |=> pin_out == $past(core_out))
    else $error("pins disturbed outside extest");
endmodule // bsc_chain

// ### dv/bsc_host.sv
// partner model: external test controller driving the serial test pins
// assumes tdo_w is the resolved serial out, with the pin pull-up applied
`timescale 1ns/100ps
module bsc_host (
  output logic tck,      // test clock, still between frames
  output logic tms,      // mode select
  output logic tdi,      // serial data in
  input wire logic tdo_w // resolved serial out
);
  // idle levels match the pin pull-ups
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // one test clock
  // pins change just after the fall, serial out is read just before the rise
  task automatic step(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    #62.5;
    o = tdo_w;
    tck <= 1'b1;
    #62.5;
    tck <= 1'b0;
  endtask

  // whole scan
  // exactly n bits are shifted, then update and back to idle
  task automatic scan(input logic ir, input logic [63:0] din, input int n,
                      output logic [63:0] dout);
    logic o;
    dout = '0;
    step(1'b0, 1'b1, o);
    step(1'b1, 1'b1, o);
    if (ir) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask
endmodule // bsc_host

// ### dv/bsc_tap_tb_top.sv
// testbench for the scan port: one task per scenario, judged in place
// assumes the controller model in bsc_host and a short boundary chain
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module bsc_tap_tb_top;
  import bsc_pkg::*;
  localparam int LEN = 8;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe_n, tdo_w;
  logic [LEN-1:0] pin_in = '0;
  logic [LEN-1:0] core_out = '0;
  logic [LEN-1:0] pin_out;
  logic [LEN-1:0] cfg_q = '0;
  logic cfg_busy = 1'b0;
  logic [UCODE_USER_W-1:0] user_sig = 7'h5b;
  logic cfg_bit, cfg_bit_vld, cfg_start;
  logic [63:0] dout;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int vld_n = 0;
  int start_n = 0;
  int n0;

  // system clock, 8 ns
  always #4 mclk = ~mclk;

  // pull-up holds the released serial out high
  assign tdo_w = tdo_oe_n ? 1'b1 : tdo;

  bsc_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo_w(tdo_w));

  bsc_tap #(.BSR_LEN(LEN)) u_dut (
    .mclk(mclk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n), .pin_in(pin_in), .core_out(core_out), .pin_out(pin_out),
    .cfg_busy(cfg_busy), .user_sig(user_sig), .cfg_bit(cfg_bit),
    .cfg_bit_vld(cfg_bit_vld), .cfg_start(cfg_start)
  );

  // collect loader pulses; the cycle ceiling cuts a hang short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cfg_bit_vld === 1'b1) begin
      cfg_q[vld_n % LEN] <= cfg_bit;
      vld_n <= vld_n + 1;
    end
    if (cfg_start === 1'b1) start_n <= start_n + 1;
    if (cyc == 40000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic wait_n(int n);
    repeat (n) @(posedge mclk);
  endtask

  // pins settle through the synchroniser before anything looks at them
  task automatic set_pins(logic [LEN-1:0] p, logic [LEN-1:0] c, logic b);
    @(posedge mclk);
    pin_in <= p;
    core_out <= c;
    cfg_busy <= b;
    wait_n(6);
  endtask

  task automatic ir(logic [IR_W-1:0] op);
    u_host.scan(1'b1, 64'(op), IR_W, dout);
    `CHK(dout[1:0], IR_CAP_PAT)
  endtask

  task automatic dr(logic [63:0] d, int n);
    u_host.scan(1'b0, d, n, dout);
  endtask

  task automatic t_id;
    `CHK(tdo_oe_n, 1'b1)
    dr(64'h0, D32_W);
    `CHK(dout[31:0], {ID_VER_DEF, ID_PART_DEF, ID_MFR_DEF, ID_LSB})
    `CHK(dout[0], 1'b1)
  endtask

  task automatic t_ucode;
    ir(OP_USERCODE);
    dr(64'h0, D32_W);
    `CHK(dout[31:0], {UCODE_FIX_DEF, user_sig})
  endtask

  // unknown opcode falls back to the single stage
  task automatic t_byp;
    logic [IR_W-1:0] ops [2];
    ops = '{OP_BYPASS, 10'h155};
    foreach (ops[k]) begin
      ir(ops[k]);
      dr(64'hb6, LEN);
      `CHK(dout[LEN-1:0], 8'h6c)
    end
  endtask

  task automatic t_sample;
    set_pins(8'ha5, 8'h3c, 1'b0);
    ir(OP_SAMPLE);
    dr(64'h96, LEN);
    `CHK(dout[LEN-1:0], 8'ha5)
    `CHK(pin_out, 8'h3c)
  endtask

  task automatic t_extest;
    ir(OP_EXTEST);
    wait_n(3);
    `CHK(pin_out, 8'h96)
    set_pins(8'h5a, 8'h3c, 1'b0);
    dr(64'h69, LEN);
    wait_n(3);
    `CHK(dout[LEN-1:0], 8'h5a)
    `CHK(pin_out, 8'h69)
  endtask

  // busy configuration: shifting goes on, capture and update do not
  task automatic t_busy;
    set_pins(8'h0f, 8'hc3, 1'b1);
    `CHK(pin_out, 8'hc3)
    dr(64'hf0, LEN);
    `CHK(dout[LEN-1:0], 8'h69)
    set_pins(8'h0f, 8'hc3, 1'b0);
    `CHK(pin_out, 8'h69)
  endtask

  task automatic t_cfg;
    ir(OP_CFG_LOAD);
    n0 = vld_n;
    dr(64'hd4, LEN);
    `CHK(dout[LEN-1:0], 8'hd4)
    wait_n(4);
    `CHK(vld_n - n0, LEN)
    `CHK(cfg_q, 8'hd4)
    ir(OP_CFG_START);
    n0 = start_n;
    dr(64'h0, 1);
    wait_n(4);
    `CHK(start_n - n0, 1)
  endtask

  // five mode-select highs reach reset from idle and reselect identity
  task automatic t_tlr;
    logic o;
    repeat (5) u_host.step(1'b1, 1'b1, o);
    dr(64'h0, D32_W);
    `CHK(dout[31:0], {ID_VER_DEF, ID_PART_DEF, ID_MFR_DEF, ID_LSB})
  endtask

  task automatic wrap_up;
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // configuration scenarios run only after the boundary tests
  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    wait_n(4);
    t_id;
    t_ucode;
    t_byp;
    t_sample;
    t_extest;
    t_busy;
    t_cfg;
    t_tlr;
    wrap_up;
  end
endmodule // bsc_tap_tb_top
